// >>> wwd_pkg.sv
// How it works
// - Prescaler phase unknown at write; timeout bounded
// - Plain halt: one more decrement, then frozen
// - Interrupt wake from halt: delayed restart
// - Reset wake: disabled unless hardware option
// - Halt-reset option turns plain halt into reset
// - Oscillator interrupt enable gives active-halt, frozen
// - Active-halt wake: interrupt immediate, reset delayed
// - Hardware option: always active, activation ignored
// - Decrement per prescaler period; reset at 40h->3Fh
// - Reload above window value causes reset
// - Activation set by software, cleared only by reset
package wwd_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] CTRL_INDEX   = 8'h2a;
   localparam logic [7:0] WINDOW_INDEX = 8'h2b;
   localparam logic [7:0] STATUS_INDEX = 8'h2c;
   localparam int         INDEX_LSB    = 2;
   localparam int         INDEX_MSB    = 9;
   // Field layout of the control register
   localparam int         ACT_BIT      = 7;
   localparam int         T6_BIT       = 6;
   localparam int         CNT_W        = 7;
   // Reset values
   localparam logic [6:0] COUNT_RESET  = 7'h7f;
   localparam logic [6:0] WINDOW_RESET = 7'h7f;
   // Counter value whose decrement expires the watchdog
   localparam logic [6:0] EXPIRE_VALUE = 7'h40;
   // Prescaler period in oscillator cycles, and wake delays in cpu clocks
   localparam int         TICK_DIV_DEFAULT = 16384;
   localparam int         WAKE_SHORT       = 256;
   localparam int         WAKE_LONG        = 4096;
   localparam int         DLY_W            = 13;
   localparam int         SYNC_STAGES      = 2;
   // AHB transfer type bit that marks an active transfer
   localparam int         HTRANS_ACTIVE    = 1;

   // Counter states, Gray-coded along run, halt, frozen, delay, run
   typedef enum logic [2:0] {
      WWD_RUN       = 3'b000,
      WWD_HALT_LAST = 3'b001,
      WWD_FROZEN    = 3'b011,
      WWD_DELAY     = 3'b010,
      WWD_ACT_HALT  = 3'b100
   } wwd_state_type;

   // Control register contents
   typedef struct packed {
      logic       watchdog_activate;
      logic [6:0] timeout_count_field;
   } wwd_ctrl_type;

   // Latched AHB address phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] index;
   } wwd_ahb_req_type;

   // Option byte straps after synchronising
   typedef struct packed {
      logic long_wake;
      logic halt_reset_option;
      logic hw_watchdog;
   } wwd_opt_type;
endpackage

// >>> wwd_prescaler.sv
`timescale 1ns/10ps
module wwd_prescaler #(
   parameter int DIV = 16384
) (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Control and strobe
   input  wire logic run,
   output logic      tick
);
   localparam int PW = $clog2(DIV);
   localparam logic [PW-1:0] LAST = PW'(DIV - 1);

   logic [PW-1:0] phase;
   logic [PW-1:0] next_phase;

   // Phase holds while frozen and is never cleared by a register write
   assign tick       = run && (phase == LAST);
   assign next_phase = !run ? phase : (tick ? '0 : phase + PW'(1));

   // Prescaler phase register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase <= '0;
      end else begin
         phase <= next_phase;
      end
   end

   // Ticks never come closer than nine cycles apart
   a_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
      tick |=> !tick [*8]) else $error("prescaler ticks too close");
endmodule

// >>> wwd_top.sv
`timescale 1ns/10ps
module wwd_top #(
   parameter int TICK_DIV = wwd_pkg::TICK_DIV_DEFAULT
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Option byte straps, asynchronous pins
   input  wire logic        opt_hw_watchdog,
   input  wire logic        opt_halt_reset,
   input  wire logic        opt_long_wake,
   // Core and clock controller, same clock
   input  wire logic        halt_request,
   input  wire logic        oscillator_interrupt_enable,
   input  wire logic        osc_interrupt,
   input  wire logic        ext_interrupt,
   // Results
   output logic             mcu_reset_req,
   output logic             cpu_halted
);
   localparam logic [wwd_pkg::DLY_W-1:0] DLY_SHORT = wwd_pkg::DLY_W'(wwd_pkg::WAKE_SHORT - 1);
   localparam logic [wwd_pkg::DLY_W-1:0] DLY_LONG  = wwd_pkg::DLY_W'(wwd_pkg::WAKE_LONG - 1);

   // Address decode used by both the read mux and the write strobes
   function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_index);
      hit = (idx == reg_index);
   endfunction

   wwd_pkg::wwd_state_type   state;
   wwd_pkg::wwd_state_type   next_state;
   wwd_pkg::wwd_ctrl_type    ctrl;
   wwd_pkg::wwd_ctrl_type    next_ctrl;
   wwd_pkg::wwd_ahb_req_type dphase;
   wwd_pkg::wwd_ahb_req_type next_dphase;
   wwd_pkg::wwd_opt_type     opt;
   logic [6:0]               window;
   logic [6:0]               next_window;
   logic [wwd_pkg::DLY_W-1:0] dly;
   logic [wwd_pkg::DLY_W-1:0] next_dly;
   logic [wwd_pkg::DLY_W-1:0] dly_last;
   logic [2:0]               sync_a;
   logic [2:0]               sync_b;
   logic [31:0]              next_rdata;
   logic                     next_reset_req;
   logic                     next_halted;
   logic                     tick;
   logic                     counting;
   logic                     dec;
   logic                     active;
   logic                     wr_ctrl;
   logic                     wr_window;
   logic                     expire;
   logic                     win_fault;
   logic                     soft_fault;
   logic                     halt_fault;
   logic                     addr_valid;
   logic [7:0]               addr_index;

   // Two-flop synchronisers for the option straps
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               sync_a[g] <= 1'b0;
               sync_b[g] <= 1'b0;
            end else begin
               sync_a[g] <= (g == 0) ? opt_hw_watchdog :
                            (g == 1) ? opt_halt_reset : opt_long_wake;
               sync_b[g] <= sync_a[g];
            end
         end
      end
   endgenerate
   assign opt = wwd_pkg::wwd_opt_type'(sync_b);

   // Prescaler; it runs only while the counter is allowed to decrement
   assign counting = (state == wwd_pkg::WWD_RUN) || (state == wwd_pkg::WWD_HALT_LAST);
   wwd_prescaler #(.DIV(TICK_DIV)) u_prescaler (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (counting),
      .tick    (tick)
   );

   // AHB address phase capture and decode
   assign addr_valid  = hsel && hready && htrans[wwd_pkg::HTRANS_ACTIVE];
   assign addr_index  = haddr[wwd_pkg::INDEX_MSB:wwd_pkg::INDEX_LSB];
   assign next_dphase = '{valid: addr_valid, write: hwrite, index: addr_index};
   assign wr_ctrl     = dphase.valid && dphase.write && hit(dphase.index, wwd_pkg::CTRL_INDEX);
   assign wr_window   = dphase.valid && dphase.write && hit(dphase.index, wwd_pkg::WINDOW_INDEX);
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;

   // Counter and activation; a write reload wins over a decrement
   assign active  = ctrl.watchdog_activate || opt.hw_watchdog;
   assign dec     = counting && tick;
   assign next_ctrl.timeout_count_field = wr_ctrl ? hwdata[wwd_pkg::CNT_W-1:0] :
                                          dec ? ctrl.timeout_count_field - 7'h01 :
                                          ctrl.timeout_count_field;
   assign next_ctrl.watchdog_activate = ctrl.watchdog_activate ||
                                        (wr_ctrl && hwdata[wwd_pkg::ACT_BIT]);
   assign next_window = wr_window ? hwdata[wwd_pkg::CNT_W-1:0] : window;

   // Fault sources that request a microcontroller reset
   assign expire     = dec && !wr_ctrl && active &&
                       (ctrl.timeout_count_field == wwd_pkg::EXPIRE_VALUE);
   assign win_fault  = wr_ctrl && active && (ctrl.timeout_count_field > window);
   assign soft_fault = wr_ctrl && !hwdata[wwd_pkg::T6_BIT] &&
                       (next_ctrl.watchdog_activate || opt.hw_watchdog);
   assign halt_fault = (state == wwd_pkg::WWD_RUN) && halt_request &&
                       !oscillator_interrupt_enable && opt.halt_reset_option;
   assign next_reset_req = mcu_reset_req || expire || win_fault || soft_fault ||
                           halt_fault;

   // Wake delay length and counter
   assign dly_last = opt.long_wake ? DLY_LONG : DLY_SHORT;
   assign next_dly = (state == wwd_pkg::WWD_DELAY) ? dly + wwd_pkg::DLY_W'(1) : '0;

   // Low-power state machine
   always_comb begin
      next_state = state;
      case (state)
         wwd_pkg::WWD_RUN: begin
            if (halt_request && !halt_fault) begin
               next_state = oscillator_interrupt_enable ? wwd_pkg::WWD_ACT_HALT
                                                        : wwd_pkg::WWD_HALT_LAST;
            end
         end
         wwd_pkg::WWD_HALT_LAST: begin
            if (ext_interrupt) begin
               next_state = wwd_pkg::WWD_DELAY;
            end else if (tick) begin
               next_state = wwd_pkg::WWD_FROZEN;
            end
         end
         wwd_pkg::WWD_FROZEN: begin
            if (ext_interrupt) begin
               next_state = wwd_pkg::WWD_DELAY;
            end
         end
         wwd_pkg::WWD_DELAY: begin
            if (dly == dly_last) begin
               next_state = wwd_pkg::WWD_RUN;
            end
         end
         wwd_pkg::WWD_ACT_HALT: begin
            if (osc_interrupt || ext_interrupt) begin
               next_state = wwd_pkg::WWD_RUN;
            end
         end
         default: next_state = wwd_pkg::WWD_DELAY;
      endcase
   end
   assign next_halted = (next_state != wwd_pkg::WWD_RUN) && (next_state != wwd_pkg::WWD_DELAY);

   // Read mux sees next values so a read right after a write returns new data
   assign next_rdata =
      !(addr_valid && !hwrite) ? hrdata :
      hit(addr_index, wwd_pkg::CTRL_INDEX)   ? {24'h000000, next_ctrl} :
      hit(addr_index, wwd_pkg::WINDOW_INDEX) ? {25'h0000000, next_window} :
      hit(addr_index, wwd_pkg::STATUS_INDEX) ? {27'h0000000, next_reset_req,
                                                opt.hw_watchdog, state} :
      32'h00000000;

   // Registers; reset leaves the counter waiting out the wake delay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state         <= wwd_pkg::WWD_DELAY;
         ctrl          <= '{watchdog_activate: 1'b0,
                            timeout_count_field: wwd_pkg::COUNT_RESET};
         window        <= wwd_pkg::WINDOW_RESET;
         dphase        <= '0;
         dly           <= 13'h0000;
         hrdata        <= 32'h00000000;
         mcu_reset_req <= 1'b0;
         cpu_halted    <= 1'b0;
      end else begin
         state         <= next_state;
         ctrl          <= next_ctrl;
         window        <= next_window;
         dphase        <= next_dphase;
         dly           <= next_dly;
         hrdata        <= next_rdata;
         mcu_reset_req <= next_reset_req;
         cpu_halted    <= next_halted;
      end
   end

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_halt_reset_opt: assert property (
      (state == wwd_pkg::WWD_RUN) && halt_request && !oscillator_interrupt_enable &&
      opt.halt_reset_option |=> mcu_reset_req && (state == wwd_pkg::WWD_RUN))
      else $error("halt with reset option did not request reset");
   a_plain_halt: assert property (
      (state == wwd_pkg::WWD_RUN) && halt_request && !oscillator_interrupt_enable &&
      !opt.halt_reset_option |=> (state == wwd_pkg::WWD_HALT_LAST))
      else $error("plain halt did not enter last decrement");
   a_frozen_hold: assert property (
      (state == wwd_pkg::WWD_FROZEN) && !wr_ctrl |=>
      $stable(ctrl.timeout_count_field) && !$rose(mcu_reset_req))
      else $error("frozen counter moved or caused reset");
   a_active_halt: assert property (
      (state == wwd_pkg::WWD_RUN) && halt_request && oscillator_interrupt_enable
      |=> (state == wwd_pkg::WWD_ACT_HALT) && !$rose(mcu_reset_req))
      else $error("active-halt not entered cleanly");
   a_ahalt_stop: assert property (
      (state == wwd_pkg::WWD_ACT_HALT) && !wr_ctrl |=> $stable(ctrl.timeout_count_field))
      else $error("counter moved in active-halt");
   a_ahalt_wake: assert property (
      (state == wwd_pkg::WWD_ACT_HALT) && osc_interrupt |=> (state == wwd_pkg::WWD_RUN))
      else $error("active-halt wake not immediate");
   a_halt_wake_delay: assert property (
      (state == wwd_pkg::WWD_FROZEN) && ext_interrupt |=>
      (state == wwd_pkg::WWD_DELAY) [*8])
      else $error("halt wake restarted too soon");
   a_delay_bound: assert property (
      (state == wwd_pkg::WWD_DELAY) |-> (dly <= DLY_LONG))
      else $error("wake delay overran");
   a_expiry: assert property (
      dec && !wr_ctrl && active &&
      (ctrl.timeout_count_field == wwd_pkg::EXPIRE_VALUE) |=> mcu_reset_req)
      else $error("expiry did not request reset");
   a_window_fault: assert property (
      wr_ctrl && active && (ctrl.timeout_count_field > window) |=> mcu_reset_req)
      else $error("early reload did not request reset");
   a_activate_sticky: assert property (
      ctrl.watchdog_activate |=> ctrl.watchdog_activate)
      else $error("activation bit cleared without reset");
   a_hw_active: assert property (
      opt.hw_watchdog && dec && !wr_ctrl &&
      (ctrl.timeout_count_field == wwd_pkg::EXPIRE_VALUE) |=> mcu_reset_req)
      else $error("hardware option did not expire");
   a_no_irq_reset_hold: assert property (mcu_reset_req |=> mcu_reset_req)
      else $error("reset request dropped");

   c_expire:  cover property (expire);
   c_window:  cover property (win_fault);
   c_halt_wk: cover property ((state == wwd_pkg::WWD_DELAY) ##1 (state == wwd_pkg::WWD_RUN));
   c_ahalt:   cover property ((state == wwd_pkg::WWD_ACT_HALT) ##1 (state == wwd_pkg::WWD_RUN));
endmodule

// >>> wwd_top_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED at %0t got %h exp %h", $time, (g), (e)); end end
module wwd_top_test;
   localparam int DIV = 16;
   logic        hclk                        = 1'b0;
   logic        hresetn                     = 1'b0;
   logic        hsel                        = 1'b0;
   logic [31:0] haddr                       = 32'h0;
   logic [1:0]  htrans                      = 2'b00;
   logic        hwrite                      = 1'b0;
   logic [2:0]  hsize                       = 3'b010;
   logic [31:0] hwdata                      = 32'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        opt_hw                      = 1'b0;
   logic        opt_halt                    = 1'b0;
   logic        opt_long                    = 1'b0;
   logic        halt_request                = 1'b0;
   logic        oscillator_interrupt_enable = 1'b0;
   logic        osc_interrupt               = 1'b0;
   logic        ext_interrupt               = 1'b0;
   logic        mcu_reset_req;
   logic        cpu_halted;
   logic [31:0] seed                        = 32'h854eb265;
   logic [31:0] rd;
   int          fail_count                  = 0;
   int          cmp_count                   = 0;
   int          cyc                         = 0;
   int          v, k, c1, c2, w;

   // The one slave's hreadyout is the bus hready
   wwd_top #(.TICK_DIV(DIV)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .opt_hw_watchdog(opt_hw), .opt_halt_reset(opt_halt), .opt_long_wake(opt_long),
      .halt_request(halt_request),
      .oscillator_interrupt_enable(oscillator_interrupt_enable),
      .osc_interrupt(osc_interrupt), .ext_interrupt(ext_interrupt),
      .mcu_reset_req(mcu_reset_req), .cpu_halted(cpu_halted));

   // Clock at 125 MHz
   always #4 hclk = ~hclk;

   // Hang guard
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 12000) begin
         fail_count++;
         $display("timeout after %0d cycles", cyc);
         close_out();
      end
   end

   // Xorshift source for random stimulus
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic wait_c(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Single word transfer: address phase, then data phase, data taken at its end
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // Reset with straps held so they pass the synchronisers
   task automatic do_reset(input logic hw, input logic hlt);
      opt_hw   <= hw;
      opt_halt <= hlt;
      hresetn  <= 1'b0;
      wait_c(2);
      hresetn  <= 1'b1;
      wait_c(3);
   endtask

   task automatic halt_pulse();
      halt_request <= 1'b1;
      wait_c(1);
      halt_request <= 1'b0;
      wait_c(1);
   endtask

   task automatic done(input string n);
      $display("test %s done", n);
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence; the model tracks counts as integers
   initial begin
      do_reset(1'b0, 1'b0);
      bus(1'b0, wwd_pkg::CTRL_INDEX, 32'h0);
      `CHK(rd[7:0], 8'h7f);
      bus(1'b0, wwd_pkg::WINDOW_INDEX, 32'h0);
      `CHK(rd[7:0], 8'h7f);
      bus(1'b0, wwd_pkg::STATUS_INDEX, 32'h0);
      `CHK(rd[4:0], {2'b00, wwd_pkg::WWD_DELAY});
      bus(1'b0, 8'h30, 32'h0);
      `CHK(rd, 32'h0);
      `CHK(hresp, 1'b0);
      done("reset");
      wait_c(260);
      // Free-running count with the watchdog disabled, random start and span
      for (int i = 0; i < 3; i++) begin
         v = 64 + int'(rnd() % 64);
         k = 1 + int'(rnd() % 4);
         bus(1'b1, wwd_pkg::CTRL_INDEX, 32'(v));
         wait_c(k * DIV);
         bus(1'b0, wwd_pkg::CTRL_INDEX, 32'h0);
         c1 = (rd[6:0] == 7'(v - k - 1)) ? v - k - 1 : v - k;
         `CHK(rd[7:0], {1'b0, 7'(c1)});
         `CHK(mcu_reset_req, 1'b0);
      end
      done("count");
      // Activation sticks; expiry at 40h to 3Fh
      bus(1'b1, wwd_pkg::CTRL_INDEX, 32'hff);
      bus(1'b1, wwd_pkg::CTRL_INDEX, 32'h7f);
      bus(1'b0, wwd_pkg::CTRL_INDEX, 32'h0);
      `CHK(rd[7], 1'b1);
      bus(1'b1, wwd_pkg::CTRL_INDEX, 32'hc1);
      wait_c(4);
      `CHK(mcu_reset_req, 1'b0);
      wait_c(2 * DIV);
      `CHK(mcu_reset_req, 1'b1);
      done("expiry");
      // Reload above the window value
      do_reset(1'b0, 1'b0);
      wait_c(260);
      bus(1'b1, wwd_pkg::CTRL_INDEX, 32'hff);
      w = 65 + int'(rnd() % 48);
      bus(1'b1, wwd_pkg::WINDOW_INDEX, 32'(w));
      bus(1'b0, wwd_pkg::WINDOW_INDEX, 32'h0);
      `CHK(rd[7:0], 8'(w));
      `CHK(mcu_reset_req, 1'b0);
      bus(1'b1, wwd_pkg::CTRL_INDEX, 32'hff);
      wait_c(2);
      `CHK(mcu_reset_req, 1'b1);
      done("window");
      // Active-halt freezes the count, oscillator interrupt resumes at once
      do_reset(1'b0, 1'b0);
      wait_c(260);
      oscillator_interrupt_enable <= 1'b1;
      bus(1'b1, wwd_pkg::CTRL_INDEX, 32'hff);
      halt_pulse();
      `CHK(cpu_halted, 1'b1);
      bus(1'b0, wwd_pkg::STATUS_INDEX, 32'h0);
      `CHK(rd[2:0], wwd_pkg::WWD_ACT_HALT);
      bus(1'b0, wwd_pkg::CTRL_INDEX, 32'h0);
      c1 = int'(rd[6:0]);
      wait_c(10 * DIV);
      bus(1'b0, wwd_pkg::CTRL_INDEX, 32'h0);
      `CHK(rd[6:0], 7'(c1));
      `CHK(mcu_reset_req, 1'b0);
      osc_interrupt <= 1'b1;
      wait_c(1);
      osc_interrupt <= 1'b0;
      wait_c(1);
      `CHK(cpu_halted, 1'b0);
      wait_c(2 * DIV + 2);
      bus(1'b0, wwd_pkg::CTRL_INDEX, 32'h0);
      `CHK(rd[6:0] != 7'(c1), 1'b1);
      done("active_halt");
      // Plain halt: one more decrement, frozen, delayed restart on interrupt
      oscillator_interrupt_enable <= 1'b0;
      bus(1'b1, wwd_pkg::CTRL_INDEX, 32'hff);
      bus(1'b0, wwd_pkg::CTRL_INDEX, 32'h0);
      c1 = int'(rd[6:0]);
      halt_pulse();
      wait_c(3 * DIV);
      bus(1'b0, wwd_pkg::CTRL_INDEX, 32'h0);
      c2 = (rd[6:0] == 7'(c1 - 2)) ? c1 - 2 : c1 - 1;
      `CHK(rd[6:0], 7'(c2));
      bus(1'b0, wwd_pkg::STATUS_INDEX, 32'h0);
      `CHK(rd[2:0], wwd_pkg::WWD_FROZEN);
      wait_c(4 * DIV);
      bus(1'b0, wwd_pkg::CTRL_INDEX, 32'h0);
      `CHK(rd[6:0], 7'(c2));
      `CHK(mcu_reset_req, 1'b0);
      ext_interrupt <= 1'b1;
      wait_c(1);
      ext_interrupt <= 1'b0;
      wait_c(1);
      bus(1'b0, wwd_pkg::STATUS_INDEX, 32'h0);
      `CHK(rd[2:0], wwd_pkg::WWD_DELAY);
      wait_c(200);
      bus(1'b0, wwd_pkg::CTRL_INDEX, 32'h0);
      `CHK(rd[6:0], 7'(c2));
      wait_c(80);
      bus(1'b0, wwd_pkg::STATUS_INDEX, 32'h0);
      `CHK(rd[2:0], wwd_pkg::WWD_RUN);
      done("halt");
      // Halt-reset option turns halt into a reset request
      do_reset(1'b0, 1'b1);
      wait_c(260);
      halt_pulse();
      `CHK(mcu_reset_req, 1'b1);
      `CHK(cpu_halted, 1'b0);
      done("halt_reset");
      // Hardware option: active although activation bit is written 0
      do_reset(1'b1, 1'b0);
      bus(1'b0, wwd_pkg::STATUS_INDEX, 32'h0);
      `CHK(rd[4:3], 2'b01);
      wait_c(260);
      bus(1'b1, wwd_pkg::CTRL_INDEX, 32'h41);
      wait_c(2 * DIV + 4);
      `CHK(mcu_reset_req, 1'b1);
      done("hw_option");
      // Long wake delay strap: the counter waits 4096 cycles after reset
      opt_long <= 1'b1;
      do_reset(1'b0, 1'b0);
      wait_c(4000);
      bus(1'b0, wwd_pkg::STATUS_INDEX, 32'h0);
      `CHK(rd[2:0], wwd_pkg::WWD_DELAY);
      `CHK(rd[4:3], 2'b00);
      wait_c(100);
      bus(1'b0, wwd_pkg::STATUS_INDEX, 32'h0);
      `CHK(rd[2:0], wwd_pkg::WWD_RUN);
      done("long_wake");
      close_out();
   end
endmodule
